//--- vrc_pkg.sv
// Purpose: shared constants for the voltage reference control register block
// Assumes: one 8-bit register in the low byte of an aligned 32-bit word
// Notes: every offset, field position, reset value and bus code lives here
package vrc_pkg;
	// ------------------------------------------------------------
	// bus geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;
	localparam int REG_W = 8;
	localparam int PAD_W = 24;
	localparam int WORD_LSB = 2;
	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;

	// ------------------------------------------------------------
	// field positions of the control register
	// ------------------------------------------------------------
	localparam int BIT_ENABLE = 7;
	localparam int BIT_READY = 6;
	localparam int BIT_TEMP_EN = 5;
	localparam int BIT_TEMP_RNG = 4;
	localparam int CMP_GAIN_LO = 2;
	localparam int ADC_GAIN_LO = 0;
	localparam int GAIN_W = 2;
	localparam int NUM_BUF = 2;

	// ------------------------------------------------------------
	// reset values and codes
	// ------------------------------------------------------------
	localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;
	localparam logic [REG_W-1:0] CTRL_WR_MASK = 8'hBF;
	localparam logic [GAIN_W-1:0] GAIN_OFF = 2'h0;
	localparam logic [GAIN_W-1:0] GAIN_1X = 2'h1;
	localparam logic [GAIN_W-1:0] GAIN_2X = 2'h2;
	localparam logic [GAIN_W-1:0] GAIN_4X = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : vrc_pkg

//--- vrc_reg_if.sv
// Purpose: carries register writes and read-back between bus slave and register
// Assumes: single register, one write strobe per cycle
// Notes: bus side drives the strobe, register side answers with read value
`timescale 1ns/1ps
interface vrc_reg_if;
	import vrc_pkg::*;
	logic wr_en;
	logic [REG_W-1:0] wdata;
	logic [REG_W-1:0] rdata;
	modport bus (output wr_en, output wdata, input rdata);
	modport regs (input wr_en, input wdata, output rdata);
endinterface : vrc_reg_if

//--- vrc_ctrl_reg.sv
// Purpose: holds the control bits and drives the analog enable and select lines
// Assumes: writes arrive already decoded and byte-qualified
// Notes: ready flag comes from a flop, never from a software write
`timescale 1ns/1ps
module vrc_ctrl_reg #(
	parameter logic READY_ALWAYS = 1'b1
) (
	input wire logic aclk,
	input wire logic aresetn,
	vrc_reg_if.regs rif,
	input wire logic ref_ready_in,
	output logic [vrc_pkg::REG_W-1:0] ctrl_q,
	output logic [vrc_pkg::NUM_BUF-1:0] buffer_on
);
	import vrc_pkg::*;

	logic [REG_W-1:0] ctrl_r;
	logic ready_r;

	// ------------------------------------------------------------
	// writable bits
	// ------------------------------------------------------------
	// software bits; the ready position is masked off on write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= CTRL_RESET; // see RULE10
		end else if (rif.wr_en) begin
			ctrl_r <= rif.wdata & CTRL_WR_MASK; // see RULE1 see RULE6 see RULE7 see RULE4
		end
	end

	// ------------------------------------------------------------
	// ready flag
	// ------------------------------------------------------------
	// set by hardware only: held at 1 when READY_ALWAYS, else once enabled and the reference reports it is settled
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ready_r <= READY_ALWAYS;
		end else if (READY_ALWAYS) begin
			ready_r <= 1'b1; // see RULE5
		end else begin
			ready_r <= ctrl_r[BIT_ENABLE] & ref_ready_in; // see RULE2 see RULE3 see RULE4
		end
	end

	// ------------------------------------------------------------
	// gain buffers
	// ------------------------------------------------------------
	// a buffer is powered for any gain code except off
	genvar g;
	generate
		for (g = 0; g < NUM_BUF; g++) begin : g_buf
			assign buffer_on[g] = (ctrl_r[g*GAIN_W +: GAIN_W] != GAIN_OFF); // see RULE8 see RULE9
		end
	endgenerate

	// read value with the live flag merged in
	always_comb begin
		ctrl_q = ctrl_r;
		ctrl_q[BIT_READY] = ready_r;
	end
	assign rif.rdata = ctrl_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_ready_always;
		@(posedge aclk) disable iff (!aresetn)
		READY_ALWAYS |=> ctrl_q[BIT_READY];
	endproperty
	a_ready_always: assert property (p_ready_always) else $error("ready flag dropped"); // see RULE5

	property p_ready_off;
		@(posedge aclk) disable iff (!aresetn)
		(!READY_ALWAYS && !ctrl_r[BIT_ENABLE]) |=> !ctrl_q[BIT_READY];
	endproperty
	a_ready_off: assert property (p_ready_off) else $error("ready set while disabled"); // see RULE3

	property p_ready_rise;
		@(posedge aclk) disable iff (!aresetn)
		(!READY_ALWAYS && ctrl_r[BIT_ENABLE] && ref_ready_in) |=> ctrl_q[BIT_READY];
	endproperty
	a_ready_rise: assert property (p_ready_rise) else $error("ready not set when settled"); // see RULE2

	property p_ready_hw;
		@(posedge aclk) disable iff (!aresetn)
		$rose(ctrl_q[BIT_READY]) |-> $past(ctrl_r[BIT_ENABLE]) || READY_ALWAYS;
	endproperty
	a_ready_hw: assert property (p_ready_hw) else $error("ready rose without enable"); // see RULE4
endmodule : vrc_ctrl_reg

//--- vrc_top.sv
// Purpose: AXI4-Lite slave for the voltage reference control register
// Assumes: one outstanding write and one outstanding read at a time
// Notes: only the word at the control offset is mapped; others answer SLVERR
//
// Function
// RULE1: enable bit switches the reference on/off
// RULE2: ready reads 1 when output usable
// RULE3: ready reads 0 when unready or disabled
// RULE4: hardware alone sets ready after settling
// RULE5: this family: ready always reads 1
// RULE6: bit 5 enables temperature indicator
// RULE7: bit 4 picks high or low range
// RULE8: bits 3:2 set comparator/DAC buffer gain
// RULE9: bits 1:0 set converter buffer gain
// RULE10: all writable bits clear on reset
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module vrc_top #(
	parameter logic READY_ALWAYS = 1'b1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [vrc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [vrc_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [vrc_pkg::STRB_W-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [vrc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [vrc_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ref_ready_in,
	output logic reference_enable,
	output logic reference_ready_flag,
	output logic temp_indicator_enable,
	output logic temp_range_select,
	output logic [vrc_pkg::GAIN_W-1:0] comparator_dac_gain_select,
	output logic [vrc_pkg::GAIN_W-1:0] converter_gain_select,
	output logic comparator_dac_buffer_on,
	output logic converter_buffer_on
);
	import vrc_pkg::*;

	vrc_reg_if rif ();

	logic aw_held_r;
	logic w_held_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic [REG_W-1:0] w_byte_r;
	logic w_lane_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [DATA_W-1:0] rdata_r;
	logic wr_go;
	logic wr_hit;
	logic rd_go;
	logic rd_hit;
	logic [REG_W-1:0] ctrl_q;
	logic [NUM_BUF-1:0] buffer_on;

	// ------------------------------------------------------------
	// write channels
	// ------------------------------------------------------------
	// address and data are caught independently, in either order
	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready = !w_held_r && !bvalid_r;
	assign wr_go = aw_held_r && w_held_r && !bvalid_r;
	assign wr_hit = (aw_addr_r[ADDR_W-1:WORD_LSB] == CTRL_OFFSET[ADDR_W-1:WORD_LSB]);

	// address holding register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_held_r <= 1'b0;
		end
	end

	// data holding register, low lane only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			w_byte_r <= '0;
			w_lane_r <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			w_byte_r <= s_axi_wdata[REG_W-1:0];
			w_lane_r <= s_axi_wstrb[0];
		end else if (wr_go) begin
			w_held_r <= 1'b0;
		end
	end

	// register strobe; a cleared low strobe leaves the byte alone
	assign rif.wr_en = wr_go && wr_hit && w_lane_r;
	assign rif.wdata = w_byte_r;

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	// ------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------
	assign s_axi_arready = !rvalid_r;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign rd_hit = (s_axi_araddr[ADDR_W-1:WORD_LSB] == CTRL_OFFSET[ADDR_W-1:WORD_LSB]);

	// read data captured at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= '0;
		end else if (rd_go) begin
			rvalid_r <= 1'b1;
			rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			rdata_r <= rd_hit ? {{PAD_W{1'b0}}, rif.rdata} : '0; // see RULE2 see RULE3
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	// ------------------------------------------------------------
	// register and analog lines
	// ------------------------------------------------------------
	vrc_ctrl_reg #(
		.READY_ALWAYS(READY_ALWAYS)
	) u_ctrl (
		.aclk(aclk),
		.aresetn(aresetn),
		.rif(rif.regs),
		.ref_ready_in(ref_ready_in),
		.ctrl_q(ctrl_q),
		.buffer_on(buffer_on)
	);

	// fields fanned out to the analog blocks
	assign reference_enable = ctrl_q[BIT_ENABLE]; // see RULE1
	assign reference_ready_flag = ctrl_q[BIT_READY];
	assign temp_indicator_enable = ctrl_q[BIT_TEMP_EN]; // see RULE6
	assign temp_range_select = ctrl_q[BIT_TEMP_RNG]; // see RULE7
	assign comparator_dac_gain_select = ctrl_q[CMP_GAIN_LO +: GAIN_W]; // see RULE8
	assign converter_gain_select = ctrl_q[ADC_GAIN_LO +: GAIN_W]; // see RULE9
	assign comparator_dac_buffer_on = buffer_on[1];
	assign converter_buffer_on = buffer_on[0];

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_reg_write;
		rif.wr_en;
	endsequence

	sequence s_addr_then_data;
		(s_axi_awvalid && s_axi_awready) ##1 (s_axi_wvalid && s_axi_wready);
	endsequence

	property p_enable_write;
		s_reg_write |=> reference_enable == $past(w_byte_r[BIT_ENABLE]);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable not taken"); // see RULE1

	property p_temp_enable;
		s_reg_write |=> temp_indicator_enable == $past(w_byte_r[BIT_TEMP_EN]);
	endproperty
	a_temp_enable: assert property (p_temp_enable) else $error("temp enable wrong"); // see RULE6

	property p_temp_range;
		s_reg_write |=> temp_range_select == $past(w_byte_r[BIT_TEMP_RNG]);
	endproperty
	a_temp_range: assert property (p_temp_range) else $error("temp range wrong"); // see RULE7

	property p_cmp_gain;
		s_reg_write |=> (comparator_dac_gain_select == $past(w_byte_r[3:2]))
			&& (comparator_dac_buffer_on == ($past(w_byte_r[3:2]) != GAIN_OFF));
	endproperty
	a_cmp_gain: assert property (p_cmp_gain) else $error("comparator gain wrong"); // see RULE8

	property p_adc_gain;
		s_reg_write |=> (converter_gain_select == $past(w_byte_r[1:0]))
			&& (converter_buffer_on == ($past(w_byte_r[1:0]) != GAIN_OFF));
	endproperty
	a_adc_gain: assert property (p_adc_gain) else $error("converter gain wrong"); // see RULE9

	property p_hold_quiet;
		!rif.wr_en |=> $stable(ctrl_q[BIT_ENABLE]) && $stable(converter_gain_select);
	endproperty
	a_hold_quiet: assert property (p_hold_quiet) else $error("field moved without write"); // see RULE1

	property p_reset_clear;
		@(posedge aclk) $rose(aresetn) |-> (ctrl_q & CTRL_WR_MASK) == CTRL_RESET;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("fields not cleared"); // see RULE10

	property p_ready_read;
		(rd_go && rd_hit) |=> s_axi_rdata[BIT_READY] == $past(reference_ready_flag);
	endproperty
	a_ready_read: assert property (p_ready_read) else $error("ready read-back wrong"); // see RULE2

	property p_split_write;
		s_addr_then_data ##1 (!bvalid_r) |=> s_axi_bvalid;
	endproperty
	a_split_write: assert property (p_split_write) else $error("split write lost");

	property p_bvalid_hold;
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bvalid_hold: assert property (p_bvalid_hold) else $error("write answer dropped");

	property p_rvalid_hold;
		(s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rvalid_hold: assert property (p_rvalid_hold) else $error("read answer dropped");

	property p_unmapped;
		(rd_go && !rd_hit) |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");

	// ------------------------------------------------------------
	// answer timing and write side effects
	// ------------------------------------------------------------
	sequence s_write_pair;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	sequence s_pair_to_reg;
		s_write_pair ##1 (wr_hit && w_lane_r);
	endsequence

	property p_write_answer;
		s_write_pair |=> ##1 s_axi_bvalid;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("write answer late");

	property p_bresp_okay;
		(wr_go && wr_hit) |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY;
	endproperty
	a_bresp_okay: assert property (p_bresp_okay) else $error("mapped write refused");

	property p_write_lands;
		s_pair_to_reg |=> (ctrl_q & CTRL_WR_MASK) == ($past(w_byte_r) & CTRL_WR_MASK);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("write did not land"); // see RULE1

	property p_lane_off;
		(wr_go && !w_lane_r) |=> $stable(ctrl_q & CTRL_WR_MASK);
	endproperty
	a_lane_off: assert property (p_lane_off) else $error("unstrobed byte written");

	property p_unmapped_write;
		(wr_go && !wr_hit) |=> $stable(ctrl_q & CTRL_WR_MASK) && s_axi_bresp == RESP_SLVERR;
	endproperty
	a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write landed");

	property p_ready_no_sw;
		(s_reg_write && !READY_ALWAYS && !ref_ready_in) |=> !reference_ready_flag;
	endproperty
	a_ready_no_sw: assert property (p_ready_no_sw) else $error("ready set by write"); // see RULE4

	property p_read_answer;
		rd_go |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read answer late");

	property p_read_pad;
		(rd_go && rd_hit) |=> s_axi_rresp == RESP_OKAY && s_axi_rdata[DATA_W-1:REG_W] == '0;
	endproperty
	a_read_pad: assert property (p_read_pad) else $error("mapped read not clean");
endmodule : vrc_top

//--- vrc_top_test.sv
// Purpose: self-checking bench for the voltage reference control register
// Assumes: register word at CTRL_OFFSET; DUT flag fixed at 1, DUT_SETTLE flag tracks settling
// Notes: bus tasks speak AXI4-Lite; past the time-zero setup every input is driven by NBA after an edge
`timescale 1ns/1ps
module vrc_top_test;
	import vrc_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic aclk;
	logic aresetn;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
	logic [STRB_W-1:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, ref_ready_in;
	logic reference_enable, reference_ready_flag, temp_indicator_enable, temp_range_select;
	logic [GAIN_W-1:0] comparator_dac_gain_select, converter_gain_select;
	logic comparator_dac_buffer_on, converter_buffer_on;
	logic settle_ready_flag;
	int fails = 0;
	int checks = 0;
	logic [1:0] resp;
	logic [DATA_W-1:0] rd;
	logic [REG_W-1:0] pats [12] = '{8'hFF, 8'h80, 8'h20, 8'h10, 8'h0C, 8'h08,
		8'h04, 8'h03, 8'h02, 8'h01, 8'hB5, 8'h00};

	vrc_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ref_ready_in(ref_ready_in),
		.reference_enable(reference_enable), .reference_ready_flag(reference_ready_flag),
		.temp_indicator_enable(temp_indicator_enable), .temp_range_select(temp_range_select),
		.comparator_dac_gain_select(comparator_dac_gain_select),
		.converter_gain_select(converter_gain_select),
		.comparator_dac_buffer_on(comparator_dac_buffer_on),
		.converter_buffer_on(converter_buffer_on));

	// second copy with the settling path live; only its ready flag is watched
	vrc_top #(.READY_ALWAYS(1'b0)) DUT_SETTLE (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(),
		.s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
		.s_axi_rvalid(), .s_axi_rready(s_axi_rready), .ref_ready_in(ref_ready_in),
		.reference_enable(), .reference_ready_flag(settle_ready_flag),
		.temp_indicator_enable(), .temp_range_select(), .comparator_dac_gain_select(),
		.converter_gain_select(), .comparator_dac_buffer_on(), .converter_buffer_on());

	// ------------------------------------------------------------
	// clock and watchdog
	// ------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// generous bound, the whole run takes under two hundred cycles
	initial begin
		repeat (5000) @(posedge aclk);
		fails++;
		end_sim();
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	// compare and count
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// one write, address and data offered together
	task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic [STRB_W-1:0] s, output logic [1:0] r);
		bit aw_done;
		bit w_done;
		aw_done = 0;
		w_done = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (!aw_done && s_axi_awready === 1'b1) begin
				aw_done = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready === 1'b1) begin
				w_done = 1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(aw_done && w_done));
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : axi_write

	// one read, data taken at the rvalid edge
	task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
		output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : axi_read

	// read back and compare register, pins and buffer enables
	task automatic chk_state(input logic [REG_W-1:0] e);
		axi_read(CTRL_OFFSET, rd, resp);
		check("rresp", {30'h0, resp}, {30'h0, RESP_OKAY});
		check("rdata", rd, {24'h0, e});
		check("pins", {24'h0, reference_enable, reference_ready_flag, temp_indicator_enable,
			temp_range_select, comparator_dac_gain_select, converter_gain_select},
			{24'h0, e});
		check("buf_on", {30'h0, comparator_dac_buffer_on, converter_buffer_on},
			{30'h0, |e[3:2], |e[1:0]});
	endtask : chk_state

	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask : do_reset

	task automatic end_sim();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		aresetn = 1'b0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_awprot = 3'h0;
		s_axi_arprot = 3'h0;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_wdata = '0;
		s_axi_wstrb = '0;
		s_axi_bready = 1'b0;
		s_axi_rready = 1'b0;
		ref_ready_in = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_state(8'h40);
		check("settle_flag", {31'h0, settle_ready_flag}, 32'h0);
		$display("test reset values done");
		// every field code, upper bytes carry junk that must be ignored
		foreach (pats[i]) begin
			axi_write(CTRL_OFFSET, {24'hA5A5A5, pats[i]}, 4'hF, resp);
			check("bresp", {30'h0, resp}, {30'h0, RESP_OKAY});
			chk_state((pats[i] & CTRL_WR_MASK) | 8'h40);
		end
		$display("test field codes done");
		// lane zero not strobed leaves the register alone
		axi_write(CTRL_OFFSET, 32'h000000FF, 4'hE, resp);
		check("bresp", {30'h0, resp}, {30'h0, RESP_OKAY});
		chk_state(8'h40);
		// unmapped word: error, no side effect, zero data
		axi_write(8'h04, 32'h000000FF, 4'hF, resp);
		check("bresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
		axi_read(8'hFC, rd, resp);
		check("rresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
		check("rdata", rd, 32'h0);
		chk_state(8'h40);
		$display("test strobe and unmapped done");
		// DUT ready flag ignores the analog input and the enable bit; the DUT_SETTLE flag follows them
		axi_write(CTRL_OFFSET, 32'h00000080, 4'hF, resp);
		check("settle_flag", {31'h0, settle_ready_flag}, 32'h0);
		ref_ready_in <= 1'b1;
		repeat (2) @(posedge aclk);
		chk_state(8'hC0);
		check("settle_flag", {31'h0, settle_ready_flag}, 32'h1);
		ref_ready_in <= 1'b0;
		repeat (2) @(posedge aclk);
		check("flag", {31'h0, reference_ready_flag}, 32'h1);
		check("settle_flag", {31'h0, settle_ready_flag}, 32'h0);
		$display("test ready flag done");
		// reset in mid-run clears every writable bit
		ref_ready_in <= 1'b1;
		axi_write(CTRL_OFFSET, 32'h000000FF, 4'hF, resp);
		chk_state(8'hFF);
		check("settle_flag", {31'h0, settle_ready_flag}, 32'h1);
		do_reset();
		chk_state(8'h40);
		check("settle_flag", {31'h0, settle_ready_flag}, 32'h0);
		$display("test second reset done");
		end_sim();
	end
endmodule : vrc_top_test
